// *** design/pdxu_exc.sv ***
`timescale 1ns/1ps
module pdxu_exc (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire pdxu_pkg::pdxu_req_type i_req,
   input wire logic [7:0] i_own_addr,
   input wire logic i_fw_update,
   input wire logic i_diag_busy,
   output pdxu_pkg::pdxu_ans_type o_ans
);
   pdxu_pkg::pdxu_ans_type q, d;
   logic [7:0] cb_diff;

   always_comb begin
      d = '0;
      cb_diff = i_req.cb_rx - i_req.cb_exp;
      if (i_req.valid && (i_req.dev_addr == i_own_addr) && !i_fw_update) begin
         d.valid = 1'b1;
         d.except = 1'b1;
         if (!i_req.fn_ok) begin
            d.code = pdxu_pkg::EXC_ILL_FUNC;
         end else if (i_req.probe_use && i_diag_busy) begin
            d.code = pdxu_pkg::EXC_ILL_FUNC;
         end else if (!i_req.range_ok) begin
            d.code = pdxu_pkg::EXC_ILL_ADDR;
         end else if (!i_req.struct_ok) begin
            d.code = pdxu_pkg::EXC_ILL_DATA;
         end else if (!i_req.field_ok) begin
            d.code = pdxu_pkg::EXC_FIELD;
         end else if (i_req.read_wo) begin
            d.code = pdxu_pkg::EXC_WR_ONLY;
         end else if (i_req.val_bad) begin
            d.code = pdxu_pkg::EXC_WR_VALUE;
            d.reject = 1'b1;
         end else if (i_req.busy) begin
            d.code = pdxu_pkg::EXC_BUSY;
         end else if (i_req.probe_unknown) begin
            d.code = pdxu_pkg::EXC_UNK_PROBE;
         end else if (i_req.bad_str) begin
            d.code = pdxu_pkg::EXC_BAD_STR;
         end else if (i_req.long_str) begin
            d.code = pdxu_pkg::EXC_LONG_STR;
         end else if (i_req.probe_tmo) begin
            d.code = pdxu_pkg::EXC_PROBE_TMO;
         end else if (i_req.crc_in_bad) begin
            d.code = pdxu_pkg::EXC_CRC_IN;
         end else if (i_req.probe_reply && (cb_diff == pdxu_pkg::CB_OFS_CRC)) begin
            d.code = pdxu_pkg::EXC_CRC_OUT;
         end else if (i_req.probe_reply && (cb_diff == pdxu_pkg::CB_OFS_FLT)) begin
            d.code = pdxu_pkg::EXC_PROBE_FLT;
         end else if (i_req.probe_reply && (cb_diff != 8'h00)) begin
            d.code = pdxu_pkg::EXC_CRC_IN;
         end else begin
            d.except = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_ans = q;
endmodule

// *** design/pdxu_memtest.sv ***
`timescale 1ns/1ps
module pdxu_memtest (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire logic [1:0] i_dev,
   input wire logic i_partial,
   input wire logic [24:0] i_span,
   output logic o_done,
   output logic o_fail,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [1:0] o_mem_dev,
   output logic [23:0] o_mem_addr,
   output logic [7:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_rdata
);
   pdxu_pkg::pdxu_mt_type q, d;
   logic [24:0] nxt;

   always_comb begin
      d = q;
      d.done = 1'b0;
      nxt = {1'b0, q.addr} + 25'h000_0001;
      // skip to next page after segment
      if (q.partial && ((q.addr & pdxu_pkg::SEG_MASK) == pdxu_pkg::SEG_MASK)) begin
         nxt = ({1'b0, q.addr} & pdxu_pkg::PAGE_MASK) + pdxu_pkg::PAGE_STEP;
      end
      case (q.st)
         pdxu_pkg::M_IDLE: begin
            if (i_start) begin
               d.st = pdxu_pkg::M_RUN;
               d.ph = 3'h0;
               d.addr = 24'h00_0000;
               d.dev = i_dev;
               d.partial = i_partial;
               d.span = i_span;
               d.fail = 1'b0;
            end
         end
         pdxu_pkg::M_RUN: begin
            if (i_mem_ack) begin
               d.ph = q.ph + 3'h1;
               case (q.ph)
                  3'h0: d.orig = i_mem_rdata;
                  3'h2: begin
                     if (i_mem_rdata != pdxu_pkg::PAT_A) begin
                        d.fail = 1'b1;
                     end
                  end
                  3'h4: begin
                     if (i_mem_rdata != pdxu_pkg::PAT_B) begin
                        d.fail = 1'b1;
                     end
                  end
                  3'h5: begin
                     d.ph = 3'h0;
                     d.addr = nxt[23:0];
                     if (nxt >= q.span) begin
                        d.st = pdxu_pkg::M_IDLE;
                        d.done = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end
         default: d.st = pdxu_pkg::M_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_done = q.done;
   assign o_fail = q.fail;
   assign o_mem_req = (q.st == pdxu_pkg::M_RUN);
   assign o_mem_we = q.ph[0] | (q.ph == 3'h5);
   assign o_mem_dev = q.dev;
   assign o_mem_addr = q.addr;
   // restore original byte last
   assign o_mem_wdata = (q.ph == 3'h1) ? pdxu_pkg::PAT_A :
                        (q.ph == 3'h3) ? pdxu_pkg::PAT_B : q.orig;
endmodule

// *** design/pdxu_top.sv ***
`timescale 1ns/1ps
module pdxu_top #(
   parameter int PROG_LEN = 65536,
   parameter int INFO_LEN = 256,
   parameter int BOOT_LEN = 8192,
   parameter int FRAM_BYTES = 32768,
   parameter int LOG_BYTES = 4194304
) (
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic I_SEL_WR,
   input wire logic [31:0] I_SEL_WDATA,
   output logic [31:0] O_SEL_VEC,
   output logic [31:0] O_FAIL_VEC,
   output logic [15:0] O_STATUS,
   output logic O_PROBE_BLOCK,
   output logic O_ADC_REQ,
   output logic [1:0] O_ADC_CH,
   input wire logic I_ADC_ACK,
   input wire logic [31:0] I_ADC_DATA,
   output logic O_FL_REQ,
   output logic [23:0] O_FL_ADDR,
   input wire logic I_FL_ACK,
   input wire logic [7:0] I_FL_DATA,
   output logic O_MEM_REQ,
   output logic O_MEM_WE,
   output logic [1:0] O_MEM_DEV,
   output logic [23:0] O_MEM_ADDR,
   output logic [7:0] O_MEM_WDATA,
   input wire logic I_MEM_ACK,
   input wire logic [7:0] I_MEM_RDATA,
   input wire logic [7:0] I_OWN_ADDR,
   input wire logic I_FW_UPDATE,
   input wire pdxu_pkg::pdxu_req_type I_REQ,
   output pdxu_pkg::pdxu_ans_type O_ANS
);
   localparam logic [23:0] PROG_LEN_W = 24'(PROG_LEN);
   localparam logic [23:0] INFO_LEN_W = 24'(INFO_LEN);
   localparam logic [23:0] BOOT_LEN_W = 24'(BOOT_LEN);
   localparam logic [24:0] FRAM_SPAN = 25'(FRAM_BYTES);
   localparam logic [24:0] LOG_SPAN = 25'(LOG_BYTES);

   pdxu_pkg::pdxu_main_type q, d;
   logic busy;
   logic mt_start;
   logic [1:0] mt_dev;
   logic mt_partial;
   logic [24:0] mt_span;
   logic mt_done;
   logic mt_fail;
   logic [31:0] sel_run;
   logic [3:0] low_idx;
   logic [23:0] ck_len;
   logic [23:0] ck_n;
   logic [31:0] ck_mask;
   logic [31:0] sum_nxt;
   logic [31:0] stored_nxt;
   logic adc_bad;

   function automatic logic [3:0] lowest(input logic [10:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = pdxu_pkg::NUM_TESTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // checksum region per selected test
   always_comb begin
      ck_len = PROG_LEN_W;
      ck_n = pdxu_pkg::CK_LONG_BYTES;
      ck_mask = pdxu_pkg::CK_LONG_MASK;
      if (q.idx == pdxu_pkg::BIT_INFO) begin
         ck_len = INFO_LEN_W;
         ck_n = pdxu_pkg::CK_SHORT_BYTES;
         ck_mask = pdxu_pkg::CK_SHORT_MASK;
      end else if (q.idx == pdxu_pkg::BIT_BOOT) begin
         ck_len = BOOT_LEN_W;
      end
   end

   // memory test setup per selected test
   always_comb begin
      mt_dev = pdxu_pkg::DEV_FRAM;
      mt_partial = 1'b0;
      mt_span = FRAM_SPAN;
      case (q.idx)
         pdxu_pkg::BIT_LOG_LO: begin
            mt_dev = pdxu_pkg::DEV_LOG_LO;
            mt_partial = 1'b1;
            mt_span = LOG_SPAN;
         end
         pdxu_pkg::BIT_LOG_HI: begin
            mt_dev = pdxu_pkg::DEV_LOG_HI;
            mt_partial = 1'b1;
            mt_span = LOG_SPAN;
         end
         pdxu_pkg::BIT_LOG_FULL: begin
            mt_dev = q.hi ? pdxu_pkg::DEV_LOG_HI : pdxu_pkg::DEV_LOG_LO;
            mt_span = LOG_SPAN;
         end
         default: ;
      endcase
   end

   // range checks on converter readings
   always_comb begin
      adc_bad = 1'b0;
      case (q.idx)
         pdxu_pkg::BIT_BATT: adc_bad = (I_ADC_DATA[15:0] < pdxu_pkg::BATT_MIN_MV);
         pdxu_pkg::BIT_TEMP: begin
            adc_bad = (I_ADC_DATA < pdxu_pkg::TEMP_MIN) || (I_ADC_DATA > pdxu_pkg::TEMP_MAX);
         end
         pdxu_pkg::BIT_PRES: begin
            adc_bad = (I_ADC_DATA < pdxu_pkg::PRES_MIN) || (I_ADC_DATA > pdxu_pkg::PRES_MAX);
         end
         default: adc_bad = 1'b0;
      endcase
   end

   always_comb begin
      d = q;
      sel_run = I_SEL_WDATA & pdxu_pkg::SEL_VALID_MASK;
      low_idx = lowest(q.pend);
      sum_nxt = q.sum;
      stored_nxt = q.stored;
      if (q.cnt < ck_len) begin
         sum_nxt = q.sum + {24'h00_0000, I_FL_DATA};
      end else begin
         stored_nxt = {q.stored[23:0], I_FL_DATA};
      end
      case (q.st)
         pdxu_pkg::S_IDLE: begin
            if (I_SEL_WR && (I_SEL_WDATA != 32'h0000_0000)) begin
               d.sel = I_SEL_WDATA;
               d.pend = sel_run[10:0];
               d.fail = pdxu_pkg::FAIL_RESET;
               d.st = pdxu_pkg::S_PICK;
            end else if (I_SEL_WR) begin
               d.sel = I_SEL_WDATA;
            end
         end
         pdxu_pkg::S_PICK: begin
            if (q.pend == 11'h000) begin
               d.st = pdxu_pkg::S_IDLE;
            end else begin
               d.idx = low_idx;
               d.pend[low_idx] = 1'b0;
               d.hi = 1'b0;
               d.cnt = 24'h00_0000;
               d.sum = 32'h0000_0000;
               d.stored = 32'h0000_0000;
               case (low_idx)
                  pdxu_pkg::BIT_BATT: begin
                     d.ch = pdxu_pkg::ADC_BATT;
                     d.st = pdxu_pkg::S_ADC;
                  end
                  pdxu_pkg::BIT_TEMP: begin
                     d.ch = pdxu_pkg::ADC_TEMP;
                     d.st = pdxu_pkg::S_ADC;
                  end
                  pdxu_pkg::BIT_PRES: begin
                     d.ch = pdxu_pkg::ADC_PRES;
                     d.st = pdxu_pkg::S_ADC;
                  end
                  pdxu_pkg::BIT_PROG: begin
                     d.fl_addr = pdxu_pkg::PROG_BASE;
                     d.st = pdxu_pkg::S_CK;
                  end
                  pdxu_pkg::BIT_INFO: begin
                     d.fl_addr = pdxu_pkg::INFO_BASE;
                     d.st = pdxu_pkg::S_CK;
                  end
                  pdxu_pkg::BIT_BOOT: begin
                     d.fl_addr = pdxu_pkg::BOOT_BASE;
                     d.st = pdxu_pkg::S_CK;
                  end
                  default: d.st = pdxu_pkg::S_MEM;
               endcase
            end
         end
         pdxu_pkg::S_ADC: begin
            if (I_ADC_ACK) begin
               d.fail[q.idx] = adc_bad;
               d.st = pdxu_pkg::S_PICK;
            end
         end
         pdxu_pkg::S_CK: begin
            if (I_FL_ACK) begin
               d.sum = sum_nxt;
               d.stored = stored_nxt;
               d.cnt = q.cnt + 24'h00_0001;
               d.fl_addr = q.fl_addr + 24'h00_0001;
               // compare sum with stored bytes
               if (q.cnt == (ck_len + ck_n - 24'h00_0001)) begin
                  d.fail[q.idx] = ((sum_nxt & ck_mask) != (stored_nxt & ck_mask));
                  d.st = pdxu_pkg::S_PICK;
               end
            end
         end
         pdxu_pkg::S_MEM: d.st = pdxu_pkg::S_MWAIT;
         pdxu_pkg::S_MWAIT: begin
            if (mt_done) begin
               if (mt_fail) begin
                  d.fail[q.idx] = 1'b1;
               end
               if ((q.idx == pdxu_pkg::BIT_LOG_FULL) && !q.hi) begin
                  d.hi = 1'b1;
                  d.st = pdxu_pkg::S_MEM;
               end else begin
                  d.st = pdxu_pkg::S_PICK;
               end
            end
         end
         default: d.st = pdxu_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_B) begin
         q <= '0;
         q.sel <= pdxu_pkg::SEL_RESET;
         q.fail <= pdxu_pkg::FAIL_RESET;
      end else begin
         q <= d;
      end
   end

   assign busy = (q.st != pdxu_pkg::S_IDLE);
   assign mt_start = (q.st == pdxu_pkg::S_MEM);

   pdxu_memtest u_memtest (
      .i_clk(I_MCLK),
      .i_rst_b(I_RST_B),
      .i_start(mt_start),
      .i_dev(mt_dev),
      .i_partial(mt_partial),
      .i_span(mt_span),
      .o_done(mt_done),
      .o_fail(mt_fail),
      .o_mem_req(O_MEM_REQ),
      .o_mem_we(O_MEM_WE),
      .o_mem_dev(O_MEM_DEV),
      .o_mem_addr(O_MEM_ADDR),
      .o_mem_wdata(O_MEM_WDATA),
      .i_mem_ack(I_MEM_ACK),
      .i_mem_rdata(I_MEM_RDATA)
   );

   pdxu_exc u_exc (
      .i_clk(I_MCLK),
      .i_rst_b(I_RST_B),
      .i_req(I_REQ),
      .i_own_addr(I_OWN_ADDR),
      .i_fw_update(I_FW_UPDATE),
      .i_diag_busy(busy),
      .o_ans(O_ANS)
   );

   always_comb begin
      O_STATUS = 16'h0000;
      O_STATUS[pdxu_pkg::STAT_BUSY_BIT] = busy;
   end

   assign O_PROBE_BLOCK = busy;
   assign O_SEL_VEC = q.sel;
   assign O_FAIL_VEC = q.fail;
   assign O_ADC_REQ = (q.st == pdxu_pkg::S_ADC);
   assign O_ADC_CH = q.ch;
   assign O_FL_REQ = (q.st == pdxu_pkg::S_CK);
   assign O_FL_ADDR = q.fl_addr;
endmodule

// *** include/pdxu_pkg.sv ***
package pdxu_pkg;
   localparam logic [31:0] SEL_VALID_MASK = 32'h0000_05FF;
   localparam logic [3:0] BIT_BATT = 4'h0;
   localparam logic [3:0] BIT_PROG = 4'h1;
   localparam logic [3:0] BIT_INFO = 4'h2;
   localparam logic [3:0] BIT_FRAM = 4'h3;
   localparam logic [3:0] BIT_LOG_LO = 4'h4;
   localparam logic [3:0] BIT_LOG_HI = 4'h5;
   localparam logic [3:0] BIT_TEMP = 4'h6;
   localparam logic [3:0] BIT_PRES = 4'h7;
   localparam logic [3:0] BIT_LOG_FULL = 4'h8;
   localparam logic [3:0] BIT_BOOT = 4'hA;
   localparam int NUM_TESTS = 11;
   localparam int STAT_BUSY_BIT = 7;
   localparam logic [31:0] SEL_RESET = 32'h0000_0000;
   localparam logic [31:0] FAIL_RESET = 32'h0000_0000;
   // battery reading is in millivolts
   localparam logic [15:0] BATT_MIN_MV = 16'h0C1C;
   localparam logic [31:0] TEMP_MIN = 32'h0074_0000;
   localparam logic [31:0] TEMP_MAX = 32'h00E5_0000;
   localparam logic [31:0] PRES_MIN = 32'h0081_0000;
   localparam logic [31:0] PRES_MAX = 32'h0B00_0000;
   localparam logic [1:0] ADC_BATT = 2'h0;
   localparam logic [1:0] ADC_TEMP = 2'h1;
   localparam logic [1:0] ADC_PRES = 2'h2;
   localparam logic [1:0] DEV_FRAM = 2'h0;
   localparam logic [1:0] DEV_LOG_LO = 2'h1;
   localparam logic [1:0] DEV_LOG_HI = 2'h2;
   localparam logic [23:0] SEG_MASK = 24'h00_01FF;
   localparam logic [24:0] PAGE_MASK = 25'h1FF_F000;
   localparam logic [24:0] PAGE_STEP = 25'h000_1000;
   localparam logic [7:0] PAT_A = 8'h55;
   localparam logic [7:0] PAT_B = 8'hAA;
   localparam logic [23:0] PROG_BASE = 24'h00_0000;
   localparam logic [23:0] INFO_BASE = 24'h80_0000;
   localparam logic [23:0] BOOT_BASE = 24'hC0_0000;
   localparam logic [23:0] CK_LONG_BYTES = 24'h00_0004;
   localparam logic [23:0] CK_SHORT_BYTES = 24'h00_0002;
   localparam logic [31:0] CK_SHORT_MASK = 32'h0000_FFFF;
   localparam logic [31:0] CK_LONG_MASK = 32'hFFFF_FFFF;
   localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_DATA = 8'h03;
   localparam logic [7:0] EXC_BUSY = 8'h06;
   localparam logic [7:0] EXC_FIELD = 8'h80;
   localparam logic [7:0] EXC_WR_ONLY = 8'h81;
   localparam logic [7:0] EXC_WR_VALUE = 8'h84;
   localparam logic [7:0] EXC_UNK_PROBE = 8'hB0;
   localparam logic [7:0] EXC_BAD_STR = 8'hB1;
   localparam logic [7:0] EXC_LONG_STR = 8'hB2;
   localparam logic [7:0] EXC_PROBE_TMO = 8'hB3;
   localparam logic [7:0] EXC_CRC_IN = 8'hB4;
   localparam logic [7:0] EXC_CRC_OUT = 8'hB5;
   localparam logic [7:0] EXC_PROBE_FLT = 8'hB6;
   localparam logic [7:0] CB_OFS_CRC = 8'h07;
   localparam logic [7:0] CB_OFS_FLT = 8'h38;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PICK = 3'b001,
      S_ADC = 3'b010,
      S_CK = 3'b011,
      S_MEM = 3'b100,
      S_MWAIT = 3'b101
   } pdxu_main_st_type;

   typedef struct packed {
      pdxu_main_st_type st;
      logic [31:0] sel;
      logic [31:0] fail;
      logic [10:0] pend;
      logic [3:0] idx;
      logic hi;
      logic [1:0] ch;
      logic [23:0] fl_addr;
      logic [23:0] cnt;
      logic [31:0] sum;
      logic [31:0] stored;
   } pdxu_main_type;

   typedef enum logic {
      M_IDLE = 1'b0,
      M_RUN = 1'b1
   } pdxu_mt_st_type;

   typedef struct packed {
      pdxu_mt_st_type st;
      logic [2:0] ph;
      logic [23:0] addr;
      logic [7:0] orig;
      logic [1:0] dev;
      logic partial;
      logic [24:0] span;
      logic fail;
      logic done;
   } pdxu_mt_type;

   typedef struct packed {
      logic valid;
      logic [7:0] dev_addr;
      logic fn_ok;
      logic range_ok;
      logic struct_ok;
      logic field_ok;
      logic read_wo;
      logic val_bad;
      logic probe_use;
      logic busy;
      logic probe_unknown;
      logic bad_str;
      logic long_str;
      logic probe_tmo;
      logic crc_in_bad;
      logic probe_reply;
      logic [7:0] cb_rx;
      logic [7:0] cb_exp;
   } pdxu_req_type;

   typedef struct packed {
      logic valid;
      logic except;
      logic [7:0] code;
      logic reject;
   } pdxu_ans_type;
endpackage

// *** testbench/pdxu_bench.sv ***
`timescale 1ns/1ps
module pdxu_bench;
   logic I_MCLK = 0;
   logic I_RST_B = 0;
   logic I_SEL_WR = 0;
   logic I_FW_UPDATE = 0;
   logic [31:0] I_SEL_WDATA = '0;
   logic [31:0] O_SEL_VEC, O_FAIL_VEC, I_ADC_DATA;
   logic [15:0] O_STATUS;
   logic O_PROBE_BLOCK, O_ADC_REQ, I_ADC_ACK, O_FL_REQ, I_FL_ACK, O_MEM_REQ, O_MEM_WE, I_MEM_ACK;
   logic [1:0] O_ADC_CH, O_MEM_DEV;
   logic [23:0] O_FL_ADDR, O_MEM_ADDR;
   logic [7:0] I_FL_DATA, O_MEM_WDATA, I_MEM_RDATA;
   logic [7:0] I_OWN_ADDR = 8'h11;
   pdxu_pkg::pdxu_req_type I_REQ = '0;
   pdxu_pkg::pdxu_req_type b, r;
   pdxu_pkg::pdxu_ans_type O_ANS;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   int bad;
   logic [7:0] codes [0:14] = '{8'h01, 8'h02, 8'h03, 8'h80, 8'h81, 8'h84, 8'h06, 8'hB0,
      8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB4};
   logic [7:0] ofs [0:2] = '{8'h07, 8'h38, 8'h03};
   logic [31:0] av [0:8] = '{32'h0000_0C1C, 32'h0074_0000, 32'h0B00_0000, 32'h0000_0C1B,
      32'h00E5_0001, 32'h0080_FFFF, 32'h0000_FFFF, 32'h00E5_0000, 32'h0081_0000};
   pdxu_top #(.PROG_LEN(8), .INFO_LEN(4), .BOOT_LEN(8), .FRAM_BYTES(16), .LOG_BYTES(8192))
      dut (.*);
   pdxu_partner p (.i_clk(I_MCLK), .i_adc_req(O_ADC_REQ), .i_adc_ch(O_ADC_CH),
      .o_adc_ack(I_ADC_ACK), .o_adc_data(I_ADC_DATA), .i_fl_req(O_FL_REQ),
      .o_fl_ack(I_FL_ACK), .o_fl_data(I_FL_DATA), .i_mem_req(O_MEM_REQ), .i_mem_we(O_MEM_WE),
      .i_mem_dev(O_MEM_DEV), .i_mem_addr(O_MEM_ADDR), .i_mem_wdata(O_MEM_WDATA),
      .o_mem_ack(I_MEM_ACK), .o_mem_rdata(I_MEM_RDATA));
   always #2.5 I_MCLK = ~I_MCLK;
   task automatic stop_test;
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge I_MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         $display("[ERR] %0t cycle limit reached", $time);
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] d);
      @(posedge I_MCLK) I_SEL_WR <= 1;
      I_SEL_WDATA <= d;
      @(posedge I_MCLK) I_SEL_WR <= 0;
   endtask
   task automatic idle;
      int n = 0;
      @(negedge I_MCLK);
      while (O_STATUS[7] && n < 30000) begin
         @(negedge I_MCLK);
         n++;
      end
      if (O_STATUS[7]) begin
         fail_count++;
         $display("[ERR] %0t self-test run did not finish", $time);
         stop_test();
      end
   endtask
   task automatic ask(input pdxu_pkg::pdxu_req_type q, input logic [10:0] e);
      @(posedge I_MCLK) I_REQ <= q;
      @(posedge I_MCLK) I_REQ.valid <= 0;
      #1;
      if (e[10]) chk({O_ANS.valid, O_ANS.except, O_ANS.reject, O_ANS.code}, e);
      else chk(O_ANS.valid, 0);
   endtask
   function automatic logic [31:0] adc_exp(input logic [31:0] v, t, s);
      adc_exp = {24'h00_0000, s < 32'h0081_0000 || s > 32'h0B00_0000,
         t < 32'h0074_0000 || t > 32'h00E5_0000, 5'h00, v[15:0] < 16'h0C1C};
   endfunction
   initial begin
      repeat (10) @(posedge I_MCLK);
      I_RST_B <= 1;
      #1;
      chk(O_SEL_VEC | O_FAIL_VEC | O_STATUS, '0);
      b = '0;
      {b.valid, b.fn_ok, b.range_ok, b.struct_ok, b.field_ok} = '1;
      b.dev_addr = I_OWN_ADDR;
      for (int i = 0; i < 15; i++) begin
         r = b;
         case (i)
            0: r.fn_ok = 0;
            1: r.range_ok = 0;
            2: r.struct_ok = 0;
            3: r.field_ok = 0;
            4: r.read_wo = 1;
            5: r.val_bad = 1;
            6: r.busy = 1;
            7: r.probe_unknown = 1;
            8: r.bad_str = 1;
            9: r.long_str = 1;
            10: r.probe_tmo = 1;
            11: r.crc_in_bad = 1;
            default: {r.probe_reply, r.cb_exp, r.cb_rx} = {9'h1F0, 8'hF0 + ofs[i - 12]};
         endcase
         ask(r, {2'b11, i == 5, codes[i]});
      end
      r = b;
      r.dev_addr = 8'h12;
      ask(r, '0);
      @(posedge I_MCLK) I_FW_UPDATE <= 1;
      ask(b, '0);
      @(posedge I_MCLK) I_FW_UPDATE <= 0;
      for (int k = 0; k < 9; k += 3) begin
         {p.adc_val[0], p.adc_val[1], p.adc_val[2], p.slow} = {av[k], av[k+1], av[k+2], k == 3};
         wr(32'h0000_00C1);
         idle();
         chk(O_FAIL_VEC, adc_exp(av[k], av[k+1], av[k+2]));
      end
      for (int k = 0; k < 2; k++) begin
         p.ck_bad = k[0];
         wr(32'h0000_0606);
         idle();
         chk(O_FAIL_VEC, k ? 32'h0000_0406 : '0);
         chk(O_FL_ADDR, 32'h00C0_000C);
      end
      wr('0);
      idle();
      chk(O_SEL_VEC | O_FAIL_VEC | O_STATUS, 32'h0000_0406);
      wr(32'h0000_0200);
      idle();
      chk(O_FAIL_VEC, '0);
      wr(32'h0000_0038);
      @(negedge I_MCLK);
      chk({O_PROBE_BLOCK, O_STATUS}, 32'h0001_0080);
      r = b;
      {r.probe_use, r.busy} = '1;
      ask(r, {3'b110, 8'h01});
      wr(32'h0000_0001);
      idle();
      chk(O_SEL_VEC | O_FAIL_VEC, 32'h0000_0038);
      chk({p.wr_cnt[0], p.wr_cnt[1], p.wr_cnt[2]}, {32'd48, 32'd3072, 32'd3072});
      p.mem_bad = 1;
      wr(32'h0000_0008);
      idle();
      chk(O_FAIL_VEC, 32'h0000_0008);
      bad = 0;
      for (int d = 0; d < 3; d++)
         for (int a = 0; a < 8192; a++)
            if (p.mem[d][a] !== ({2'b00, 6'(a)} ^ 8'(d))) bad++;
      chk(bad, 0);
      wr(32'h0000_0100);
      repeat (20) @(negedge I_MCLK);
      chk({O_MEM_REQ, O_MEM_DEV, O_STATUS}, {3'b101, 16'h0080});
      @(posedge I_MCLK) I_RST_B <= 0;
      repeat (2) @(posedge I_MCLK);
      I_RST_B <= 1;
      #1;
      chk(O_SEL_VEC | O_FAIL_VEC | O_STATUS | O_MEM_REQ, '0);
      p.adc_val[0] = 32'h0000_0C1B;
      wr(32'h0000_0001);
      idle();
      chk(O_FAIL_VEC, 32'h0000_0001);
      stop_test();
   end
endmodule

// *** testbench/pdxu_monitor.sv ***
`timescale 1ns/1ps
module pdxu_monitor (
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic I_SEL_WR,
   input wire logic [31:0] I_SEL_WDATA,
   input wire logic [31:0] O_SEL_VEC,
   input wire logic [31:0] O_FAIL_VEC,
   input wire logic [15:0] O_STATUS,
   input wire logic O_PROBE_BLOCK,
   input wire logic [7:0] I_OWN_ADDR,
   input wire logic I_FW_UPDATE,
   input wire pdxu_pkg::pdxu_req_type I_REQ,
   input wire pdxu_pkg::pdxu_ans_type O_ANS
);
   logic bsy;
   logic hit;
   assign bsy = O_STATUS[7];
   assign hit = I_REQ.valid && I_REQ.dev_addr == I_OWN_ADDR && !I_FW_UPDATE;
   default clocking @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RST_B);
   reply_hit_a:
      assert property (hit |=> O_ANS.valid) else $error("answer missing");
   no_stray_a:
      assert property (O_ANS.valid |-> $past(hit)) else $error("stray answer");
   probe_busy_a:
      assert property (hit && I_REQ.fn_ok && I_REQ.probe_use && I_REQ.busy && bsy
         |=> O_ANS.except && O_ANS.code == 8'h01) else $error("busy probe code");
   bad_func_a:
      assert property (hit && !I_REQ.fn_ok |=> O_ANS.code == 8'h01) else $error("func code");
   reject_code_a:
      assert property (O_ANS.reject |-> O_ANS.code == 8'h84) else $error("reject code");
   run_start_a:
      assert property (I_SEL_WR && !bsy && I_SEL_WDATA != '0 |=> bsy && O_FAIL_VEC == '0
         && O_SEL_VEC == $past(I_SEL_WDATA)) else $error("run start");
   zero_keep_a:
      assert property (I_SEL_WR && !bsy && I_SEL_WDATA == '0 |=> !bsy && $stable(O_FAIL_VEC))
         else $error("zero write");
   result_hold_a:
      assert property (!bsy && !I_SEL_WR |=> $stable(O_FAIL_VEC)) else $error("result moved");
   block_flag_a:
      assert property (O_PROBE_BLOCK == bsy) else $error("block flag");
   rsvd_clear_a:
      assert property ((O_FAIL_VEC & ~pdxu_pkg::SEL_VALID_MASK) == '0) else $error("rsvd fail");
   cover property (bsy && I_REQ.valid);
   cover property (O_ANS.valid && O_ANS.code == 8'hB6);
   cover property (O_ANS.reject);
endmodule
bind pdxu_top pdxu_monitor mon (.*);

// *** testbench/pdxu_partner.sv ***
`timescale 1ns/1ps
module pdxu_partner (
   input wire logic i_clk,
   input wire logic i_adc_req,
   input wire logic [1:0] i_adc_ch,
   output logic o_adc_ack,
   output logic [31:0] o_adc_data,
   input wire logic i_fl_req,
   output logic o_fl_ack,
   output logic [7:0] o_fl_data,
   input wire logic i_mem_req,
   input wire logic i_mem_we,
   input wire logic [1:0] i_mem_dev,
   input wire logic [23:0] i_mem_addr,
   input wire logic [7:0] i_mem_wdata,
   output logic o_mem_ack,
   output logic [7:0] o_mem_rdata
);
   logic [31:0] adc_val [0:3];
   logic [7:0] mem [0:3][0:8191];
   logic [31:0] wr_cnt [0:3];
   logic ck_bad, mem_bad, slow;
   logic [1:0] dly;
   logic [7:0] cur;
   assign cur = mem[i_mem_dev][i_mem_addr[12:0]];
   initial begin
      {ck_bad, mem_bad, slow, dly, o_adc_ack, o_fl_ack, o_mem_ack} = '0;
      {o_adc_data, o_fl_data, o_mem_rdata} = '0;
      for (int d = 0; d < 4; d++) begin
         adc_val[d] = '0;
         wr_cnt[d] = '0;
         for (int a = 0; a < 8192; a++) mem[d][a] = {2'b00, 6'(a)} ^ 8'(d);
      end
   end
   // answers prompt or slow; idle data lines keep toggling
   always @(posedge i_clk) begin
      dly <= (i_adc_req && !o_adc_ack) ? dly + 2'd1 : 2'd0;
      o_adc_ack <= i_adc_req && !o_adc_ack && (!slow || dly == 2'd3);
      o_adc_data <= (i_adc_req && !o_adc_ack) ? adc_val[i_adc_ch] : ~o_adc_data;
      o_fl_ack <= i_fl_req && !o_fl_ack;
      o_fl_data <= (i_fl_req && !o_fl_ack) ? {7'h00, ck_bad} : ~o_fl_data;
      o_mem_ack <= i_mem_req && !o_mem_ack;
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_req && !o_mem_ack) begin
         o_mem_rdata <= (mem_bad && cur == 8'h55) ? 8'h54 : cur;
         if (i_mem_we) begin
            mem[i_mem_dev][i_mem_addr[12:0]] <= i_mem_wdata;
            wr_cnt[i_mem_dev] <= wr_cnt[i_mem_dev] + 1;
         end
      end
   end
endmodule
